// *** include/scx_params.svh ***
`ifndef SCX_PARAMS_SVH
`define SCX_PARAMS_SVH

// Register byte offsets within the system control space.
`define SCX_ICS_OFF 16'hed04
`define SCX_VTB_OFF 16'hed08
`define SCX_AIRC_OFF 16'hed0c
`define SCX_SPC_OFF 16'hed10
`define SCX_IST_OFF 16'hed40
`define SCX_IMSK_OFF 16'hed44

// Interrupt control state fields.
`define SCX_PREEMPT_BIT 23
`define SCX_EXTWAIT_BIT 22
`define SCX_TOPPEND_LSB 12
`define SCX_ACTIVE_LSB 0

// Vector table base field.
`define SCX_VBASE_LSB 8
`define SCX_VBASE_RST 24'h00_0000

// Reset control fields.
`define SCX_KEY_LSB 16
`define SCX_KEY_VAL 16'h05fa
`define SCX_BYTE_ORDER_BIT 15
`define SCX_BYTE_ORDER_VAL 1'b0
`define SCX_SYSRST_BIT 2
`define SCX_CLRACT_BIT 1

// Power control fields.
`define SCX_WAKEANY_BIT 4
`define SCX_DEEP_BIT 2
`define SCX_EXITLP_BIT 1

// Interrupt status bits.
`define SCX_EV_WAKE 0
`define SCX_EV_SYSRST 1
`define SCX_EV_CLRACT 2

// External interrupt lines start at this exception number.
`define SCX_IRQ_BASE 9'h010
`define SCX_NUM_IRQ 32

`endif

// *** include/scx_pkg.sv ***
package scx_pkg;
    typedef enum logic {
        SCX_RUN,
        SCX_WFE
    } scx_wait_t;
    typedef logic [8:0] scx_exc_num_t;
    typedef logic [2:0] scx_ev_t;
endpackage

// *** include/scx_reg_if.sv ***
`timescale 1ns/100ps
interface scx_reg_if;
    logic rd_en;
    logic wr_en;
    logic [15:0] addr;
    logic [31:0] wr_data;
    modport bus (
        output rd_en,
        output wr_en,
        output addr,
        output wr_data
    );
    modport regs (
        input rd_en,
        input wr_en,
        input addr,
        input wr_data
    );
endinterface

// *** rtl/scx_ahb_front.sv ***
`timescale 1ns/100ps
module scx_ahb_front
    import scx_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic hreadyout,
    scx_reg_if.bus rif
);
    logic take;
    logic rd_pend_r;
    logic wr_pend_r;
    logic [15:0] addr_r;

    assign take = hsel & htrans[1] & hready;

    // Reads take one wait state so that a write just before is seen.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_pend_r <= 1'b0;
            wr_pend_r <= 1'b0;
            hreadyout <= 1'b1;
        end else begin
            rd_pend_r <= take & ~hwrite;
            wr_pend_r <= take & hwrite;
            hreadyout <= ~(take & ~hwrite);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            addr_r <= 16'h0000;
        end else if (take) begin
            addr_r <= haddr[15:0];
        end
    end

    assign rif.rd_en = rd_pend_r;
    assign rif.wr_en = wr_pend_r;
    assign rif.addr = addr_r;
    assign rif.wr_data = hwdata;
endmodule

// *** rtl/scx_pend_enc.sv ***
`timescale 1ns/100ps
module scx_pend_enc #(
    parameter int N = 32,
    parameter int W = 5
) (
    input wire logic [N-1:0] vec,
    output logic found,
    output logic [W-1:0] idx
);
    // Lower line number wins; it stands in for a fixed priority order.
    always_comb begin
        found = 1'b0;
        idx = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (vec[i]) begin
                found = 1'b1;
                idx = W'(i);
            end
        end
    end
endmodule

// *** rtl/scx_top.sv ***
// What this block does
// - Preempt flag bit 23, readable only when halted
// - Take pending interrupt on resume unless masked
// - Bit 22 shows any external interrupt pending
// - Bits 20:12 give top pending number
// - Top pending honours enables, ignores priority mask
// - Bits 8:0 give active number, reset zero
// - Vector base bits 31:8, reset zero
// - Reset control writes need key 05FA, else ignored
// - Keyed bit 2 write raises reset request
// - Reset request clears halt, keeps debugger
// - Clear-active only from halted debugger, self-clears
// - Clear-active zeroes active state, forces Thread
// - Bit 4 lets disabled interrupts wake too
// - Pending event wakes wait, else latched
// - Send-event or external event also wakes
// - Bit 2 picks sleep or deep sleep
// - Bit 1 sleeps on return to Thread
//
// The AHB-Lite register port was chosen for this implementation.
`timescale 1ns/100ps
`include "scx_params.svh"
module scx_top
    import scx_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [31:0] irq_pending,
    input wire logic [31:0] irq_enable,
    input wire logic core_halted,
    input wire logic debug_irq_mask,
    input wire logic dbg_access,
    input wire logic exc_entry,
    input wire logic exc_return_thread,
    input wire logic wfe_start,
    input wire logic sev_exec,
    input wire logic ext_event,
    output logic system_reset_request,
    output logic halt_status_clear,
    output logic clear_active_state,
    output logic irq_take,
    output logic core_wake,
    output logic deep_low_power_select,
    output logic low_power_enter,
    output logic irq_out
);
    scx_reg_if rif();

    logic [23:0] vector_base_field_r;
    logic wake_on_any_pend_r;
    logic low_power_on_handler_return_r;
    logic [2:0] irq_stat_r;
    logic [2:0] irq_mask_r;
    scx_exc_num_t active_exc_num_r;
    scx_exc_num_t top_pending_exc_num_r;
    logic ext_irq_waiting_r;
    logic halted_d_r;
    logic [31:0] pend_d_r;
    logic event_latch_r;
    logic event_latch_nxt;
    scx_wait_t wait_r;
    scx_wait_t wait_nxt;
    logic wake_go;
    logic [31:0] enabled_pend;
    logic [31:0] new_pend;
    logic [31:0] wake_pend;
    logic wake_src;
    logic enc_found;
    logic [4:0] enc_idx;
    scx_exc_num_t top_num;
    logic wr_ics;
    logic wr_vtb;
    logic wr_airc;
    logic wr_spc;
    logic wr_imsk;
    logic key_ok;
    logic sysrst_go;
    logic clract_go;
    logic rd_stat;
    scx_ev_t events;
    logic [31:0] rd_data;
    logic preempt_now;

    scx_ahb_front u_front (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hready(hready),
        .hwdata(hwdata),
        .hreadyout(hreadyout),
        .rif(rif.bus)
    );

    // Only enable registers qualify the search; the core's priority
    // mask is deliberately not an input here.
    assign enabled_pend = irq_pending & irq_enable;

    scx_pend_enc #(
        .N(`SCX_NUM_IRQ),
        .W(5)
    ) u_enc (
        .vec(enabled_pend),
        .found(enc_found),
        .idx(enc_idx)
    );

    assign top_num = enc_found ? ({4'h0, enc_idx} + `SCX_IRQ_BASE)
                               : 9'h000;

    // Bus decode. Size is not checked: only whole words are expected.
    assign wr_ics = rif.wr_en && rif.addr == `SCX_ICS_OFF;
    assign wr_vtb = rif.wr_en && rif.addr == `SCX_VTB_OFF;
    assign wr_airc = rif.wr_en && rif.addr == `SCX_AIRC_OFF;
    assign wr_spc = rif.wr_en && rif.addr == `SCX_SPC_OFF;
    assign wr_imsk = rif.wr_en && rif.addr == `SCX_IMSK_OFF;
    assign rd_stat = rif.rd_en && rif.addr == `SCX_IST_OFF;

    assign key_ok = rif.wr_data[31:`SCX_KEY_LSB] == `SCX_KEY_VAL;
    assign sysrst_go = wr_airc & key_ok
                     & rif.wr_data[`SCX_SYSRST_BIT];
    // A core-side write, or one while running, cannot clear state
    // that the handler is still using.
    assign clract_go = wr_airc & key_ok & rif.wr_data[`SCX_CLRACT_BIT]
                     & dbg_access & core_halted;

    assign preempt_now = core_halted
                       && top_pending_exc_num_r != 9'h000;

    // Read data, built from live state in the wait state of the read.
    always_comb begin
        rd_data = 32'h0000_0000;
        if (rif.addr == `SCX_ICS_OFF) begin
            rd_data[`SCX_PREEMPT_BIT] = preempt_now;
            rd_data[`SCX_EXTWAIT_BIT] = ext_irq_waiting_r;
            rd_data[`SCX_TOPPEND_LSB +: 9] = top_pending_exc_num_r;
            rd_data[`SCX_ACTIVE_LSB +: 9] = active_exc_num_r;
        end else if (rif.addr == `SCX_VTB_OFF) begin
            rd_data[31:`SCX_VBASE_LSB] = vector_base_field_r;
        end else if (rif.addr == `SCX_AIRC_OFF) begin
            // The key field has no storage and reads as zero.
            rd_data[`SCX_BYTE_ORDER_BIT] = `SCX_BYTE_ORDER_VAL;
            rd_data[`SCX_SYSRST_BIT] = system_reset_request;
        end else if (rif.addr == `SCX_SPC_OFF) begin
            rd_data[`SCX_WAKEANY_BIT] = wake_on_any_pend_r;
            rd_data[`SCX_DEEP_BIT] = deep_low_power_select;
            rd_data[`SCX_EXITLP_BIT] = low_power_on_handler_return_r;
        end else if (rif.addr == `SCX_IST_OFF) begin
            rd_data[2:0] = irq_stat_r;
        end else if (rif.addr == `SCX_IMSK_OFF) begin
            rd_data[2:0] = irq_mask_r;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (rif.rd_en) begin
            hrdata <= rd_data;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hresp <= 1'b0;
        end else begin
            hresp <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            vector_base_field_r <= `SCX_VBASE_RST;
        end else if (wr_vtb) begin
            vector_base_field_r <= rif.wr_data[31:`SCX_VBASE_LSB];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wake_on_any_pend_r <= 1'b0;
            deep_low_power_select <= 1'b0;
            low_power_on_handler_return_r <= 1'b0;
        end else if (wr_spc) begin
            wake_on_any_pend_r <= rif.wr_data[`SCX_WAKEANY_BIT];
            deep_low_power_select <= rif.wr_data[`SCX_DEEP_BIT];
            low_power_on_handler_return_r <= rif.wr_data[`SCX_EXITLP_BIT];
        end
    end

    // The request holds until the outer system resets this block.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            system_reset_request <= 1'b0;
        end else if (sysrst_go) begin
            system_reset_request <= 1'b1;
        end
    end

    // Halt clear is a pulse; the debug link itself is never touched.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            halt_status_clear <= 1'b0;
        end else begin
            halt_status_clear <= sysrst_go;
        end
    end

    // The control pulses in the cycle after it is written and reads back zero.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clear_active_state <= 1'b0;
        end else begin
            clear_active_state <= clract_go;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            active_exc_num_r <= 9'h000;
        end else if (clract_go) begin
            active_exc_num_r <= 9'h000;
        end else if (exc_entry) begin
            active_exc_num_r <= top_pending_exc_num_r;
        end else if (exc_return_thread) begin
            active_exc_num_r <= 9'h000;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            top_pending_exc_num_r <= 9'h000;
            ext_irq_waiting_r <= 1'b0;
        end else begin
            top_pending_exc_num_r <= top_num;
            ext_irq_waiting_r <= |irq_pending;
        end
    end

    // On leaving halt, the interrupt flagged as preempting is taken
    // unless the debugger masks interrupts.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            halted_d_r <= 1'b0;
            irq_take <= 1'b0;
        end else begin
            halted_d_r <= core_halted;
            irq_take <= halted_d_r & ~core_halted & ~debug_irq_mask
                      & (top_pending_exc_num_r != 9'h000);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            low_power_enter <= 1'b0;
        end else begin
            low_power_enter <= exc_return_thread
                             & low_power_on_handler_return_r;
        end
    end

    // Wake sources. A line counts as new on its rising edge only, so a
    // level left pending does not keep waking the core.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pend_d_r <= 32'h0000_0000;
        end else begin
            pend_d_r <= irq_pending;
        end
    end

    assign new_pend = irq_pending & ~pend_d_r;
    assign wake_pend = wake_on_any_pend_r ? new_pend
                                          : (new_pend & irq_enable);
    assign wake_src = (|wake_pend) | sev_exec | ext_event;

    always_comb begin
        wait_nxt = wait_r;
        event_latch_nxt = event_latch_r;
        wake_go = 1'b0;
        case (wait_r)
            SCX_RUN: begin
                if (wfe_start) begin
                    if (event_latch_r | wake_src) begin
                        wake_go = 1'b1;
                        event_latch_nxt = 1'b0;
                    end else begin
                        wait_nxt = SCX_WFE;
                    end
                end else if (wake_src) begin
                    event_latch_nxt = 1'b1;
                end
            end
            SCX_WFE: begin
                if (wake_src) begin
                    wake_go = 1'b1;
                    wait_nxt = SCX_RUN;
                end
            end
            default: begin
                wait_nxt = SCX_RUN;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wait_r <= SCX_RUN;
        end else begin
            wait_r <= wait_nxt;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            event_latch_r <= 1'b0;
        end else begin
            event_latch_r <= event_latch_nxt;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            core_wake <= 1'b0;
        end else begin
            core_wake <= wake_go;
        end
    end

    // Interrupt status: a new event in the cycle of the clearing read
    // survives, so it is never lost.
    assign events = {clract_go, sysrst_go, wake_go};

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_stat_r <= 3'h0;
        end else if (rd_stat) begin
            irq_stat_r <= events;
        end else begin
            irq_stat_r <= irq_stat_r | events;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_mask_r <= 3'h0;
        end else if (wr_imsk) begin
            irq_mask_r <= rif.wr_data[2:0];
        end
    end

    // Registered from next-state terms so the line rises with the bit.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_out <= 1'b0;
        end else if (rd_stat) begin
            irq_out <= |(events & irq_mask_r);
        end else if (wr_imsk) begin
            irq_out <= |((irq_stat_r | events) & rif.wr_data[2:0]);
        end else begin
            irq_out <= |((irq_stat_r | events) & irq_mask_r);
        end
    end

    // The interrupt control state register has no writable field here.
    logic unused_ok;
    assign unused_ok = wr_ics | (|hsize);
endmodule

// *** test/scx_sys_model.sv ***
`timescale 1ns/100ps
module scx_sys_model (
    input wire logic hclk,
    input wire logic halt_set,
    input wire logic halt_rel,
    input wire logic halt_status_clear,
    output logic core_halted
);
    // The debugger is not reset by hresetn, so its halt state survives.
    initial core_halted = 1'b0;
    always @(posedge hclk) begin
        if (halt_status_clear) begin
            core_halted <= 1'b0;
        end else if (halt_set) begin
            core_halted <= 1'b1;
        end else if (halt_rel) begin
            core_halted <= 1'b0;
        end
    end
endmodule

// *** test/scx_top_monitor.sv ***
`timescale 1ns/100ps
module scx_top_monitor (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hwrite,
    input wire logic core_halted,
    input wire logic debug_irq_mask,
    input wire logic wfe_start,
    input wire logic sev_exec,
    input wire logic ext_event,
    input wire logic exc_return_thread,
    input wire logic system_reset_request,
    input wire logic halt_status_clear,
    input wire logic clear_active_state,
    input wire logic irq_take,
    input wire logic core_wake,
    input wire logic deep_low_power_select,
    input wire logic low_power_enter
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    AST_SYSRST_HOLD: assert property (system_reset_request |=> system_reset_request) else $error("reset request dropped");
    AST_HALT_CLR: assert property ($rose(system_reset_request) |-> halt_status_clear) else $error("halt clear missing");
    AST_HALT_PULSE: assert property (halt_status_clear |=> !halt_status_clear) else $error("halt clear too long");
    AST_CLR_HALTED: assert property (clear_active_state |-> $past(core_halted) && $past(hwrite, 2)) else $error("clear active not from halt");
    AST_CLR_PULSE: assert property (clear_active_state |=> !clear_active_state) else $error("clear active stuck");
    AST_TAKE: assert property (irq_take |-> !$past(core_halted) && $past(core_halted, 2) && !$past(debug_irq_mask)) else $error("bad irq take");
    AST_WAKE_NOW: assert property (wfe_start && (sev_exec || ext_event) |=> core_wake) else $error("no wake");
    AST_LOW_POWER: assert property (low_power_enter |-> $past(exc_return_thread)) else $error("bad low power entry");
    AST_DEEP_WR: assert property ($changed(deep_low_power_select) |-> $past(hwrite, 2)) else $error("deep select moved");
    cover property (core_wake);
    cover property (irq_take);
    cover property ($rose(system_reset_request));
endmodule
bind scx_top scx_top_monitor mon_u (.hclk(hclk), .hresetn(hresetn),
    .hwrite(hwrite), .core_halted(core_halted),
    .debug_irq_mask(debug_irq_mask), .wfe_start(wfe_start),
    .sev_exec(sev_exec), .ext_event(ext_event),
    .exc_return_thread(exc_return_thread),
    .system_reset_request(system_reset_request),
    .halt_status_clear(halt_status_clear),
    .clear_active_state(clear_active_state), .irq_take(irq_take),
    .core_wake(core_wake), .deep_low_power_select(deep_low_power_select),
    .low_power_enter(low_power_enter));

// *** test/tb.sv ***
`timescale 1ns/100ps
`include "scx_params.svh"
module tb;
    import scx_pkg::*;
    typedef struct {
        logic [15:0] a;
        logic [31:0] d;
        logic [31:0] e;
    } scx_row_t;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [1:0] htrans = 2'b00;
    logic [31:0] haddr = '0, hwdata = '0, irq_pending = '0, irq_enable = '0;
    logic debug_irq_mask = 1'b0, dbg_access = 1'b0;
    logic halt_set = 1'b0, halt_rel = 1'b0;
    logic [4:0] ev = '0;
    logic [31:0] hrdata, q;
    logic hreadyout, hresp, system_reset_request, halt_status_clear;
    logic clear_active_state, irq_take, core_wake, deep_low_power_select;
    logic low_power_enter, irq_out, core_halted;
    int mismatches = 0, checks_done = 0, base = 0;
    int cnt [3] = '{0, 0, 0};
    logic [15:0] rst_addr [6] = '{`SCX_ICS_OFF, `SCX_VTB_OFF, `SCX_AIRC_OFF,
        `SCX_SPC_OFF, `SCX_IST_OFF, `SCX_IMSK_OFF};
    scx_row_t rows [7] = '{
        '{`SCX_VTB_OFF, 32'hffff_ffff, 32'hffff_ff00},
        '{`SCX_SPC_OFF, 32'hffff_ffff, 32'h0000_0016},
        '{`SCX_SPC_OFF, 32'h0000_0000, 32'h0000_0000},
        '{`SCX_AIRC_OFF, 32'h0000_0004, 32'h0000_0000},
        '{`SCX_ICS_OFF, 32'hffff_ffff, 32'h0000_0000},
        '{16'hed80, 32'hffff_ffff, 32'h0000_0000},
        '{`SCX_VTB_OFF, 32'h0000_1200, 32'h0000_1200}};
    always #12.5 hclk = ~hclk;
    scx_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
        .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .irq_pending(irq_pending),
        .irq_enable(irq_enable), .core_halted(core_halted),
        .debug_irq_mask(debug_irq_mask), .dbg_access(dbg_access),
        .exc_entry(ev[4]), .exc_return_thread(ev[3]), .wfe_start(ev[2]),
        .sev_exec(ev[1]), .ext_event(ev[0]),
        .system_reset_request(system_reset_request),
        .halt_status_clear(halt_status_clear),
        .clear_active_state(clear_active_state), .irq_take(irq_take),
        .core_wake(core_wake), .deep_low_power_select(deep_low_power_select),
        .low_power_enter(low_power_enter), .irq_out(irq_out));
    scx_sys_model model_u (.hclk(hclk), .halt_set(halt_set),
        .halt_rel(halt_rel), .halt_status_clear(halt_status_clear),
        .core_halted(core_halted));
    always @(posedge hclk) begin
        if (core_wake === 1'b1) cnt[0]++;
        if (low_power_enter === 1'b1) cnt[1]++;
        if (irq_take === 1'b1) cnt[2]++;
    end
    task automatic chk(input string nm, input logic [31:0] e, g);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic ahb(input logic w, input logic [15:0] a,
            input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {16'h0000, a};
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        q = hrdata;
    endtask
    task automatic rd(input logic [15:0] a, input logic [31:0] m, e,
            input string nm);
        ahb(1'b0, a, 32'h0000_0000);
        chk(nm, e, q & m);
    endtask
    task automatic pulse(input logic [4:0] v);
        ev <= v;
        @(posedge hclk);
        ev <= '0;
        repeat (2) @(posedge hclk);
    endtask
    task automatic halt(input logic h);
        halt_set <= h;
        halt_rel <= !h;
        @(posedge hclk);
        halt_set <= 1'b0;
        halt_rel <= 1'b0;
        repeat (3) @(posedge hclk);
    endtask
    task automatic do_reset;
        hresetn <= 1'b0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        #100us;
        mismatches++;
        print_verdict();
    end
    initial begin
        do_reset();
        foreach (rst_addr[i]) rd(rst_addr[i], '1, '0, "reset");
        foreach (rows[i]) begin
            ahb(1'b1, rows[i].a, rows[i].d);
            rd(rows[i].a, '1, rows[i].e, "row");
        end
        irq_enable <= 32'h0000_0020;
        irq_pending <= 32'h0000_0030;
        repeat (2) @(posedge hclk);
        rd(`SCX_ICS_OFF, 32'h007f_f1ff, 32'h0041_5000, "pend");
        irq_enable <= '0;
        repeat (2) @(posedge hclk);
        rd(`SCX_ICS_OFF, 32'h001f_f1ff, 32'h0, "unen");
        irq_enable <= 32'h0000_0020;
        repeat (2) @(posedge hclk);
        pulse(5'b10000);
        rd(`SCX_ICS_OFF, 32'h1ff, 32'h15, "active");
        ahb(1'b1, `SCX_SPC_OFF, 32'h0000_0006);
        pulse(5'b01000);
        chk("lowpwr", 1, cnt[1]);
        chk("deep", 1, {31'b0, deep_low_power_select});
        rd(`SCX_ICS_OFF, 32'h1ff, 32'h0, "thread");
        ahb(1'b1, `SCX_SPC_OFF, 32'h0000_0000);
        pulse(5'b10000);
        pulse(5'b01000);
        chk("nolowpwr", 1, cnt[1]);
        pulse(5'b10000);
        halt(1'b1);
        rd(`SCX_ICS_OFF, 32'h0080_0000, 32'h0080_0000, "preempt");
        ahb(1'b1, `SCX_AIRC_OFF, 32'h05fa_0002);
        rd(`SCX_ICS_OFF, 32'h1ff, 32'h15, "clr_sw");
        dbg_access <= 1'b1;
        ahb(1'b1, `SCX_AIRC_OFF, 32'h05fa_0002);
        dbg_access <= 1'b0;
        rd(`SCX_ICS_OFF, 32'h1ff, 32'h0, "clr_dbg");
        // The second release runs masked, so the take count must not move.
        for (int m = 0; m < 2; m++) begin
            debug_irq_mask <= m[0];
            halt(1'b0);
            chk("take", 1, cnt[2]);
            halt(1'b1);
        end
        irq_enable <= '0;
        irq_pending <= '0;
        pulse(5'b00010);
        pulse(5'b00100);
        base = cnt[0];
        pulse(5'b00100);
        chk("nowake", base, cnt[0]);
        pulse(5'b00010);
        chk("sev", base + 1, cnt[0]);
        pulse(5'b00001);
        pulse(5'b00100);
        chk("latched", base + 2, cnt[0]);
        pulse(5'b00110);
        chk("same", base + 3, cnt[0]);
        pulse(5'b00100);
        irq_pending <= 32'h0000_0001;
        repeat (3) @(posedge hclk);
        chk("disabled", base + 3, cnt[0]);
        irq_pending <= '0;
        ahb(1'b1, `SCX_SPC_OFF, 32'h0000_0010);
        irq_pending <= 32'h0000_0001;
        repeat (3) @(posedge hclk);
        chk("anypend", base + 4, cnt[0]);
        chk("irq_masked", 0, {31'b0, irq_out});
        ahb(1'b1, `SCX_IMSK_OFF, 32'h0000_0001);
        @(posedge hclk);
        chk("irq_on", 1, {31'b0, irq_out});
        rd(`SCX_IST_OFF, 32'h7, 32'h5, "status");
        @(posedge hclk);
        chk("irq_off", 0, {31'b0, irq_out});
        ahb(1'b1, `SCX_AIRC_OFF, 32'h05fa_0004);
        // The halt clear pulse needs one more edge to reach the model.
        repeat (2) @(posedge hclk);
        chk("sysreq", 1, {31'b0, system_reset_request});
        chk("halted", 0, {31'b0, core_halted});
        rd(`SCX_AIRC_OFF, '1, 32'h0000_0004, "airc");
        chk("hresp", 0, {31'b0, hresp});
        do_reset();
        chk("sysreq_rst", 0, {31'b0, system_reset_request});
        rd(`SCX_VTB_OFF, '1, 32'h0, "vtb_rst");
        print_verdict();
    end
endmodule
